// File: verilog/mods_top.sv
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
// Behaviour
// R1: Eight entries, each speed, torque, ramp times.
// R2: Per-entry selectors: 0 digital, 3 external.
// R3: Selectors reset 0, apply after stop.
// R4: Both selectors external raises setting error.
// R5: Erroneous entry selected: no start, prohibited.
// R6: External mode analog or PWM, default analog.
// R7: Speed accepts 0 or 80..3150, reset 0.
// R8: Digital values used only when selected digital.
// R9: Torque limit 0..200 percent, reset 200.
// R10: Acceleration 0.1..15.0 s, reset 0.5, immediate.
// R11: Deceleration 0.1..15.0 s, reset 0.5, immediate.
// R12: Ramp times refer to 3000 r/min.
// R13: PWM mode uses measured duty cycle.
// R14: Limit enable on limits torque, else peak.
// R15: No assigned enable terminal means always on.
// R16: Several assigned terminals need all on.
// R17: Limiting active output on while limiting.
// R18: Host ignores limiting output at low speed.
// R19: Zero speed bypasses the lower limit.
// R20: Ramp rate is 3000 over ramp time.
// R21: Out-of-range writes rejected, old value kept.
module mods_top #(
    parameter int EN_PINS = 4,
    parameter int PWM_PERIOD = 4000,
    parameter int TENTH_S = mods_pkg::TENTH_S_CYCLES,
    parameter logic [11:0] SPEED_LOWER = 12'h0050,
    parameter logic [11:0] PEAK_TORQUE = 12'h0FFF
) (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Register port.
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Torque limit enable terminals and their assignment mask.
    input wire logic [EN_PINS-1:0] i_torque_limit_enable_input,
    input wire logic [EN_PINS-1:0] i_en_assign,
    // External analog level and PWM terminal.
    input wire logic [7:0] i_ext_analog,
    input wire logic i_ext_pwm,
    // Measured motor torque in percent of rated.
    input wire logic [11:0] i_motor_torque,
    // Motor commands and flags.
    output logic [11:0] o_speed_cmd,
    output logic [11:0] o_torque_cmd,
    output logic o_running,
    output logic o_setting_error,
    output logic o_prohibited,
    output logic o_torque_limiting_active_output
);

    // Bus request bundled into the package struct.
    mods_pkg::mods_bus_t bus;
    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    // Entry storage; live selectors are split from the written ones. see R1
    mods_pkg::mods_entry_t entry [mods_pkg::ENTRY_COUNT];
    logic [1:0] sel_speed_src [mods_pkg::ENTRY_COUNT];
    logic [1:0] sel_torque_src [mods_pkg::ENTRY_COUNT];
    logic [7:0] err_vec;
    // Control bits.
    logic run_req;
    logic pwm_mode;
    logic [2:0] op_sel;
    logic prohibited;
    mods_pkg::mods_state_t state;

    // Entry addressing decode.
    logic in_entry;
    logic [2:0] wr_idx;
    logic [1:0] wr_fld;
    assign in_entry = bus.addr >= mods_pkg::OFS_ENTRY_BASE;
    assign wr_idx = 3'((bus.addr - mods_pkg::OFS_ENTRY_BASE) >> 4);
    assign wr_fld = bus.addr[3:2];

    // Synchronisers for the enable, analog and PWM terminals.
    logic [EN_PINS-1:0] en_s1, en_s2;
    logic [7:0] an_s1, an_s2;
    logic pwm_s1, pwm_s2;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            en_s1 <= '0;
            en_s2 <= '0;
            an_s1 <= '0;
            an_s2 <= '0;
            pwm_s1 <= 1'b0;
            pwm_s2 <= 1'b0;
        end else begin
            en_s1 <= i_torque_limit_enable_input;
            en_s2 <= en_s1;
            an_s1 <= i_ext_analog;
            an_s2 <= an_s1;
            pwm_s1 <= i_ext_pwm;
            pwm_s2 <= pwm_s1;
        end
    end

    // Per-entry storage and range checks, one generate loop.
    genvar g;
    generate
        for (g = 0; g < mods_pkg::ENTRY_COUNT; g++) begin : g_entry
            logic hit;
            logic [11:0] sp;
            logic [7:0] tv;
            assign hit = bus.wr && in_entry && (wr_idx == 3'(g));
            assign sp = bus.wdata[11:0];
            assign tv = bus.wdata[7:0];
            // Entry fields: out-of-range values leave the old contents. see R21
            always_ff @(posedge i_clk_sys) begin
                if (!i_rst_b) begin
                    entry[g].speed <= mods_pkg::SPEED_RESET;  // see R7
                    entry[g].torque <= mods_pkg::TORQUE_RESET;  // see R9
                    entry[g].accel <= mods_pkg::TIME_RESET;  // see R10
                    entry[g].decel <= mods_pkg::TIME_RESET;  // see R11
                    entry[g].speed_src <= mods_pkg::SRC_DIGITAL;  // see R3
                    entry[g].torque_src <= mods_pkg::SRC_DIGITAL;
                end else if (hit) begin
                    case (wr_fld)
                        mods_pkg::FLD_SPEED: begin
                            // Zero or 80..3150 accepted. see R7
                            if (bus.wdata[31:12] == 20'h0_0000 &&
                                (sp == 12'h000 || (sp >= mods_pkg::SPEED_MIN &&
                                 sp <= mods_pkg::SPEED_MAX))) begin
                                entry[g].speed <= sp;
                            end
                            // Codes other than 0 and 3 are ignored. see R2
                            if (bus.wdata[17:16] == mods_pkg::SRC_DIGITAL ||
                                bus.wdata[17:16] == mods_pkg::SRC_EXTERNAL) begin
                                entry[g].speed_src <= bus.wdata[17:16];
                            end
                        end
                        mods_pkg::FLD_TORQUE: begin
                            if (bus.wdata[15:8] == 8'h00 &&
                                tv <= mods_pkg::TORQUE_MAX) begin  // see R9
                                entry[g].torque <= tv;
                            end
                            if (bus.wdata[17:16] == mods_pkg::SRC_DIGITAL ||
                                bus.wdata[17:16] == mods_pkg::SRC_EXTERNAL) begin
                                entry[g].torque_src <= bus.wdata[17:16];
                            end
                        end
                        mods_pkg::FLD_ACCEL: begin
                            if (bus.wdata[15:8] == 8'h00 && tv >= mods_pkg::TIME_MIN &&
                                tv <= mods_pkg::TIME_MAX) begin  // see R10
                                entry[g].accel <= tv;
                            end
                        end
                        default: begin
                            if (bus.wdata[15:8] == 8'h00 && tv >= mods_pkg::TIME_MIN &&
                                tv <= mods_pkg::TIME_MAX) begin  // see R11
                                entry[g].decel <= tv;
                            end
                        end
                    endcase
                end
            end
            // Live selectors follow the written ones only while stopped. see R3
            always_ff @(posedge i_clk_sys) begin
                if (!i_rst_b) begin
                    sel_speed_src[g] <= mods_pkg::SRC_DIGITAL;
                    sel_torque_src[g] <= mods_pkg::SRC_DIGITAL;
                end else if (state == mods_pkg::MODS_IDLE) begin
                    sel_speed_src[g] <= entry[g].speed_src;
                    sel_torque_src[g] <= entry[g].torque_src;
                end
            end
            // Both sources external is a setting error. see R4
            assign err_vec[g] = (sel_speed_src[g] == mods_pkg::SRC_EXTERNAL) &&
                                (sel_torque_src[g] == mods_pkg::SRC_EXTERNAL);
        end
    endgenerate

    // Control register: run request, external mode, entry select.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            run_req <= 1'b0;
            pwm_mode <= 1'b0;  // see R6
            op_sel <= 3'h0;
        end else if (bus.wr && bus.addr == mods_pkg::OFS_CTRL) begin
            run_req <= bus.wdata[mods_pkg::CTRL_RUN_BIT];
            pwm_mode <= bus.wdata[mods_pkg::CTRL_PWM_BIT];  // see R6
            op_sel <= bus.wdata[mods_pkg::CTRL_SEL_LSB +: 3];
        end
    end

    // PWM duty measurement: high count over a fixed period. see R13
    logic [15:0] pwm_cnt, pwm_high;
    logic [7:0] pwm_duty;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            pwm_cnt <= '0;
            pwm_high <= '0;
            pwm_duty <= '0;
        end else if (pwm_cnt == 16'(PWM_PERIOD - 1)) begin
            pwm_cnt <= '0;
            pwm_high <= 16'(pwm_s2);
            pwm_duty <= 8'((32'(pwm_high) * 255) / PWM_PERIOD);  // see R13
        end else begin
            pwm_cnt <= pwm_cnt + 16'h0001;
            pwm_high <= pwm_high + 16'(pwm_s2);
        end
    end

    // External value as a 0..255 fraction, by the selected mode. see R6
    logic [7:0] ext_val;
    assign ext_val = pwm_mode ? pwm_duty : an_s2;

    // Target speed and torque of the chosen entry. see R8
    logic [11:0] tgt_speed, ext_speed;
    logic [7:0] tgt_torque, ext_torque;
    logic [19:0] sp_scale;
    assign sp_scale = (20'(ext_val) * 20'(mods_pkg::SPEED_MAX)) / 20'h0_00FF;
    assign ext_speed = (sp_scale[11:0] < mods_pkg::SPEED_MIN) ? 12'h000 : sp_scale[11:0];
    assign ext_torque = 8'((16'(ext_val) * 16'(mods_pkg::TORQUE_MAX)) / 16'h00FF);
    assign tgt_speed = (sel_speed_src[op_sel] == mods_pkg::SRC_EXTERNAL) ?
                       ext_speed : entry[op_sel].speed;
    assign tgt_torque = (sel_torque_src[op_sel] == mods_pkg::SRC_EXTERNAL) ?
                        ext_torque : entry[op_sel].torque;

    // Run state machine; a flagged entry never starts. see R5
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            state <= mods_pkg::MODS_IDLE;
            prohibited <= 1'b0;
        end else begin
            case (state)
                mods_pkg::MODS_IDLE: begin
                    if (run_req && err_vec[op_sel]) begin
                        prohibited <= 1'b1;  // see R5
                    end else if (run_req) begin
                        prohibited <= 1'b0;
                        state <= mods_pkg::MODS_RUN;
                    end else begin
                        prohibited <= 1'b0;
                    end
                end
                mods_pkg::MODS_RUN: begin
                    if (!run_req) begin
                        state <= mods_pkg::MODS_STOP;
                    end
                end
                mods_pkg::MODS_STOP: begin
                    // Stopped once the ramp reaches zero.
                    if (o_speed_cmd == 12'h000) begin
                        state <= mods_pkg::MODS_IDLE;
                    end else if (run_req) begin
                        state <= mods_pkg::MODS_RUN;
                    end
                end
                default: state <= mods_pkg::MODS_IDLE;
            endcase
        end
    end

    // Ramp tick: one r/min step every (time * tenth) / 3000 cycles. see R12
    logic [31:0] tick_cnt, tick_len;
    logic [11:0] ramp_goal;
    logic ramp_up;
    assign ramp_goal = (state == mods_pkg::MODS_RUN) ? tgt_speed : 12'h000;
    assign ramp_up = ramp_goal > o_speed_cmd;
    // Ramp time changes apply at once, as they are read live. see R20
    assign tick_len = (32'(ramp_up ? entry[op_sel].accel : entry[op_sel].decel) *
                       32'(TENTH_S)) / 32'(mods_pkg::SPEED_REF);
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            tick_cnt <= '0;
            o_speed_cmd <= 12'h000;
        end else if (ramp_goal == o_speed_cmd) begin
            tick_cnt <= '0;
        end else if (tick_cnt + 32'h0000_0001 >= tick_len) begin
            tick_cnt <= '0;
            // Zero goes straight through, no lower limit clamp. see R19
            if (ramp_up) begin
                o_speed_cmd <= (o_speed_cmd < SPEED_LOWER && ramp_goal >= SPEED_LOWER) ?
                               SPEED_LOWER : o_speed_cmd + 12'h001;  // see R20
            end else begin
                o_speed_cmd <= o_speed_cmd - 12'h001;  // see R20
            end
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
        end
    end

    // Torque limit enable: unassigned pins count as on. see R15 see R16
    logic en_ok;
    assign en_ok = &(en_s2 | ~i_en_assign);

    // Torque command and limiting flag. see R14 see R17
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_torque_cmd <= PEAK_TORQUE;
            o_torque_limiting_active_output <= 1'b0;
            o_running <= 1'b0;
            o_setting_error <= 1'b0;
            o_prohibited <= 1'b0;
        end else begin
            o_torque_cmd <= en_ok ? 12'(tgt_torque) : PEAK_TORQUE;  // see R14
            o_torque_limiting_active_output <= en_ok && o_running &&
                (i_motor_torque >= 12'(tgt_torque));  // see R17
            o_running <= state != mods_pkg::MODS_IDLE;
            o_setting_error <= |err_vec;  // see R4
            o_prohibited <= prohibited;  // see R5
        end
    end

    // Read data, one cycle after the read strobe; unmapped reads below 0x40 give zero.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_rdata <= '0;
        end else if (bus.rd) begin
            o_rdata <= '0;
            if (in_entry) begin
                case (wr_fld)
                    mods_pkg::FLD_SPEED: o_rdata <= {14'h0, entry[wr_idx].speed_src,
                                                     4'h0, entry[wr_idx].speed};
                    mods_pkg::FLD_TORQUE: o_rdata <= {14'h0, entry[wr_idx].torque_src,
                                                      8'h0, entry[wr_idx].torque};
                    mods_pkg::FLD_ACCEL: o_rdata <= {24'h0, entry[wr_idx].accel};
                    default: o_rdata <= {24'h0, entry[wr_idx].decel};
                endcase
            end else begin
                case (bus.addr)
                    mods_pkg::OFS_CTRL: o_rdata <= {25'h0, op_sel, 2'h0, pwm_mode, run_req};
                    mods_pkg::OFS_STATUS: o_rdata <= {16'h0, err_vec, 4'h0,
                        o_torque_limiting_active_output, prohibited, state};
                    mods_pkg::OFS_EXT_VALUE: o_rdata <= {24'h0, ext_val};
                    mods_pkg::OFS_ACTIVE_SPEED: o_rdata <= {20'h0, o_speed_cmd};
                    mods_pkg::OFS_ACTIVE_TORQUE: o_rdata <= {20'h0, o_torque_cmd};
                    default: o_rdata <= '0;
                endcase
            end
        end else begin
            o_rdata <= '0;
        end
    end

endmodule

// File: verilog/mods_pkg.sv
package mods_pkg;

    // Number of operation data entries and index width.
    localparam int ENTRY_COUNT = 8;
    localparam int ENTRY_IDX_W = 3;

    // Register offsets, one word each, byte addressed.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_EXT_VALUE = 8'h08;
    localparam logic [7:0] OFS_ACTIVE_SPEED = 8'h0C;
    localparam logic [7:0] OFS_ACTIVE_TORQUE = 8'h10;
    localparam logic [7:0] OFS_ENTRY_BASE = 8'h40;
    localparam logic [7:0] OFS_ENTRY_STRIDE = 8'h10;

    // Field positions inside an entry block, by word index.
    localparam logic [1:0] FLD_SPEED = 2'h0;
    localparam logic [1:0] FLD_TORQUE = 2'h1;
    localparam logic [1:0] FLD_ACCEL = 2'h2;
    localparam logic [1:0] FLD_DECEL = 2'h3;

    // Bit positions in the control register.
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_PWM_BIT = 1;
    localparam int CTRL_SEL_LSB = 4;
    // Bit positions of the selectors in the speed and torque words.
    localparam int SRC_LSB = 16;

    // Source selector codes.
    localparam logic [1:0] SRC_DIGITAL = 2'h0;
    localparam logic [1:0] SRC_EXTERNAL = 2'h3;

    // Accepted ranges and reset values; times are in tenths of a second.
    localparam logic [11:0] SPEED_MIN = 12'h050;
    localparam logic [11:0] SPEED_MAX = 12'hC4E;
    localparam logic [11:0] SPEED_RESET = 12'h000;
    localparam logic [11:0] SPEED_REF = 12'hBB8;
    localparam logic [7:0] TORQUE_MAX = 8'hC8;
    localparam logic [7:0] TORQUE_RESET = 8'hC8;
    localparam logic [7:0] TIME_MIN = 8'h01;
    localparam logic [7:0] TIME_MAX = 8'h96;
    localparam logic [7:0] TIME_RESET = 8'h05;

    // Clock and ramp tick: the ramp moves one speed step per tick.
    localparam int CLK_HZ = 40_000_000;
    localparam int TENTH_S_CYCLES = CLK_HZ / 10;

    // Entry contents carried together.
    typedef struct packed {
        logic [1:0] speed_src;
        logic [1:0] torque_src;
        logic [11:0] speed;
        logic [7:0] torque;
        logic [7:0] accel;
        logic [7:0] decel;
    } mods_entry_t;

    // Register bus request carried together.
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } mods_bus_t;

    // Run state of the motor command path.
    typedef enum logic [1:0] {
        MODS_IDLE = 2'b00,
        MODS_RUN = 2'b01,
        MODS_STOP = 2'b11
    } mods_state_t;

endpackage

// File: dv/mods_checker.sv
`timescale 1ns/100ps
// Port-level checks of the operation data block.
module mods_checker #(
    parameter int EN_PINS = 4,
    parameter logic [11:0] SPEED_LOWER = 12'h050,
    parameter logic [11:0] PEAK_TORQUE = 12'hFFF
) (
    // Clock, reset and the ports that are watched.
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [EN_PINS-1:0] i_torque_limit_enable_input,
    input wire logic [EN_PINS-1:0] i_en_assign,
    input wire logic [11:0] i_motor_torque,
    input wire logic [11:0] o_speed_cmd,
    input wire logic [11:0] o_torque_cmd,
    input wire logic o_running,
    input wire logic o_prohibited,
    input wire logic o_torque_limiting_active_output
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    // High while some assigned enable terminal is off.
    wire logic lim_off = (i_en_assign != '0) &&
        ((i_torque_limit_enable_input & i_en_assign) != i_en_assign);

    a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
        else $error("read data not zero outside a read answer");
    a_prohib_no_start: assert property (o_prohibited |-> !o_running)
        else $error("motor runs while start is prohibited");
    a_peak_when_off: assert property (lim_off [*5] |-> o_torque_cmd == PEAK_TORQUE)
        else $error("torque not at peak with limiting disabled");
    a_limit_when_on: assert property ((!lim_off && o_running) [*5] |->
        o_torque_cmd <= 12'h0C8)
        else $error("torque command above the limit range");
    a_flag_has_cause: assert property (o_torque_limiting_active_output |->
        i_motor_torque >= o_torque_cmd || $past(i_motor_torque) >= $past(o_torque_cmd) ||
        $past(i_motor_torque, 2) >= $past(o_torque_cmd, 2))
        else $error("limiting flag without torque at the limit");
    a_speed_in_range: assert property (o_speed_cmd <= 12'hC4E)
        else $error("speed command above the top of range");
    a_speed_slew: assert property (o_speed_cmd > $past(o_speed_cmd) + 12'h001 |->
        o_speed_cmd == SPEED_LOWER)
        else $error("speed command stepped too fast");
    a_idle_speed_zero: assert property (!o_running [*2] |-> o_speed_cmd == 12'h000)
        else $error("speed command while not running");

    // Main scenarios seen at least once.
    c_prohibited: cover property (o_prohibited);
    c_limiting: cover property (o_torque_limiting_active_output);
    c_top_speed: cover property (o_speed_cmd == 12'hC4E);
endmodule

bind mods_top mods_checker #(.EN_PINS(EN_PINS), .SPEED_LOWER(SPEED_LOWER),
    .PEAK_TORQUE(PEAK_TORQUE)) chk_u (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_rd(i_rd), .o_rdata(o_rdata),
    .i_torque_limit_enable_input(i_torque_limit_enable_input),
    .i_en_assign(i_en_assign), .i_motor_torque(i_motor_torque),
    .o_speed_cmd(o_speed_cmd), .o_torque_cmd(o_torque_cmd), .o_running(o_running),
    .o_prohibited(o_prohibited),
    .o_torque_limiting_active_output(o_torque_limiting_active_output));

// File: dv/mods_ext_src.sv
`timescale 1ns/100ps
// External setting source: an analog level and a PWM pin with a chosen duty.
module mods_ext_src #(
    parameter int PERIOD = 16
) (
    // Clock.
    input wire logic i_clk_sys,
    // Level and duty wanted by the bench.
    input wire logic [7:0] i_level,
    input wire logic [4:0] i_duty,
    // Shared external terminal.
    output logic [7:0] o_level,
    output logic o_pwm
);
    // Position inside the PWM period.
    logic [4:0] cnt = 5'h00;

    // The analog level reaches the terminal as is.
    assign o_level = i_level;
    // The pin is high for the first duty counts of each period.
    assign o_pwm = (cnt < i_duty);

    // Free-running period counter.
    always_ff @(posedge i_clk_sys) begin
        cnt <= (cnt == 5'(PERIOD - 1)) ? 5'h00 : cnt + 5'h01;
    end
endmodule

// File: dv/motor_operation_data_select_tb.sv
`timescale 1ns/100ps
// Self-checking bench: register accesses, run control and torque limiting.
module motor_operation_data_select_tb;
    // Design inputs, all set at time zero.
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [3:0] i_torque_limit_enable_input = 4'h0;
    logic [3:0] i_en_assign = 4'h0;
    logic [11:0] i_motor_torque = 12'h000;
    logic [7:0] ana = 8'h00;
    logic [4:0] duty = 5'h00;
    // Design outputs and source wires.
    wire logic [31:0] o_rdata;
    wire logic [11:0] o_speed_cmd, o_torque_cmd;
    wire logic o_running, o_setting_error, o_prohibited, o_torque_limiting_active_output;
    wire logic [7:0] ext_level;
    wire logic ext_pwm;
    // Counters of mismatches and comparisons.
    int n_fail = 0;
    int num_checks = 0;
    int n;
    // Range table: field, written value, value expected back.
    logic [1:0] tf [12] = '{0, 0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 3};
    logic [11:0] tw [12] = '{12'h04F, 12'hC4F, 12'h050, 12'hC4E, 12'h000, 12'h0C9, 12'h000,
        12'h0C8, 12'h000, 12'h097, 12'h096, 12'h097};
    logic [11:0] te [12] = '{12'h000, 12'h000, 12'h050, 12'hC4E, 12'h000, 12'h0C8, 12'h000,
        12'h0C8, 12'h005, 12'h005, 12'h096, 12'h005};

    // 40 MHz clock.
    always #12.5 i_clk_sys = ~i_clk_sys;

    // Shorter ramp tick and PWM period keep the run brief.
    mods_top #(.TENTH_S(3000), .PWM_PERIOD(16)) dut_u (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_torque_limit_enable_input(i_torque_limit_enable_input),
        .i_en_assign(i_en_assign), .i_ext_analog(ext_level), .i_ext_pwm(ext_pwm),
        .i_motor_torque(i_motor_torque), .o_speed_cmd(o_speed_cmd),
        .o_torque_cmd(o_torque_cmd), .o_running(o_running),
        .o_setting_error(o_setting_error), .o_prohibited(o_prohibited),
        .o_torque_limiting_active_output(o_torque_limiting_active_output));

    // Model of the external setting source.
    mods_ext_src #(.PERIOD(16)) src_u (.i_clk_sys(i_clk_sys), .i_level(ana),
        .i_duty(duty), .o_level(ext_level), .o_pwm(ext_pwm));

    // Prints the verdict and ends the run.
    task automatic summarize();
        if (n_fail == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Address of a field inside an entry block.
    function automatic logic [7:0] ea(input int e, input int f);
        return 8'h40 + 8'(e * 16 + f * 4);
    endfunction

    // One-cycle register write.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask

    // One-cycle read; data is taken in the following cycle.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 chk("rdata", o_rdata, exp);
    endtask

    // Waits, with a bound, for the speed command to reach a value.
    task automatic wait_spd(input logic [11:0] exp);
        int k;
        for (k = 0; k < 20000 && o_speed_cmd !== exp; k++) begin
            @(posedge i_clk_sys);
            #1;
        end
        if (k == 20000) begin
            n_fail++;
            summarize();
        end
    endtask

    // Lets some cycles pass, then samples settled outputs.
    task automatic pause(input int c);
        repeat (c) @(posedge i_clk_sys);
        #1;
    endtask

    // Main sequence.
    initial begin
        repeat (12) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        // Reset contents of all eight entries, then status and a hole.
        for (n = 0; n < 8; n++) begin
            rd(ea(n, 0), 32'h0000_0000);
            rd(ea(n, 1), 32'h0000_00C8);
            rd(ea(n, 2), 32'h0000_0005);
            rd(ea(n, 3), 32'h0000_0005);
        end
        rd(8'h04, 32'h0000_0000);
        rd(8'h30, 32'h0000_0000);
        // Boundary writes, out-of-range ones must leave the old value.
        for (n = 0; n < 12; n++) begin
            wr(ea(3, tf[n]), {20'h0_0000, tw[n]});
            rd(ea(3, tf[n]), {20'h0_0000, te[n]});
        end
        // Both sources external on entry 2; an unknown code is ignored.
        wr(ea(2, 0), 32'h0003_0000);
        wr(ea(2, 1), 32'h0001_00C8);
        rd(8'h04, 32'h0000_0000);
        wr(ea(2, 1), 32'h0003_00C8);
        rd(8'h04, 32'h0000_0400);
        chk("setting_error", o_setting_error, 1'b1);
        wr(8'h00, 32'h0000_0021);
        pause(4);
        chk("prohibited", o_prohibited, 1'b1);
        chk("running", o_running, 1'b0);
        rd(8'h04, 32'h0000_0404);
        wr(8'h00, 32'h0000_0000);
        pause(3);
        chk("prohibited", o_prohibited, 1'b0);
        wr(ea(2, 1), 32'h0000_00C8);
        rd(8'h04, 32'h0000_0000);
        // Digital run on entry 1 with the fastest ramps.
        wr(ea(1, 0), 32'h0000_0064);
        wr(ea(1, 1), 32'h0000_0032);
        wr(ea(1, 2), 32'h0000_0001);
        wr(ea(1, 3), 32'h0000_0001);
        ana <= 8'hFF;
        wr(8'h00, 32'h0000_0011);
        wait_spd(12'h064);
        chk("speed_cmd", o_speed_cmd, 12'h064);
        // No terminal assigned: limiting is on.
        i_motor_torque <= 12'h03C;
        pause(6);
        chk("torque_cmd", o_torque_cmd, 12'h032);
        chk("limiting", o_torque_limiting_active_output, 1'b1);
        // Two terminals assigned, only one on: peak torque.
        i_en_assign <= 4'h3;
        i_torque_limit_enable_input <= 4'h1;
        pause(8);
        chk("torque_cmd", o_torque_cmd, 12'hFFF);
        chk("limiting", o_torque_limiting_active_output, 1'b0);
        i_torque_limit_enable_input <= 4'h3;
        pause(8);
        chk("torque_cmd", o_torque_cmd, 12'h032);
        i_motor_torque <= 12'h028;
        pause(6);
        chk("limiting", o_torque_limiting_active_output, 1'b0);
        // Selector changed while running must wait for the stop.
        wr(ea(1, 0), 32'h0003_0064);
        pause(20);
        chk("speed_cmd", o_speed_cmd, 12'h064);
        wr(8'h00, 32'h0000_0010);
        wait_spd(12'h000);
        pause(4);
        chk("running", o_running, 1'b0);
        // Analog source at full scale after the stop.
        wr(8'h00, 32'h0000_0011);
        wait_spd(12'hC4E);
        chk("speed_cmd", o_speed_cmd, 12'hC4E);
        wr(8'h00, 32'h0000_0010);
        wait_spd(12'h000);
        // PWM mode reads the pin, held low, not the analog level.
        wr(8'h00, 32'h0000_0013);
        pause(300);
        chk("speed_cmd", o_speed_cmd, 12'h000);
        // Half duty on the pin gives half of the top speed.
        duty <= 5'h08;
        wait_spd(12'h620);
        chk("speed_cmd", o_speed_cmd, 12'h620);
        summarize();
    end
endmodule
